/* File: spss_pkg.sv */
// What this block does
// RULE1 - One rate strap sets rate for all ports.
// RULE2 - Codes 00/01/10 give 1.25/2.5/3.125; 11 illegal.
// RULE3 - Ports run at strapped rate after reset.
// RULE4 - Apply rate after hard reset and self-reset.
// RULE5 - Board holds straps steady ten clocks.
// RULE6 - Ignore strap later; software may override rate.
// RULE7 - Rate field initial value equals strap.
// RULE8 - Receive strap reverses lanes on ports 0,6.
// RULE9 - Transmit strap reverses lanes on ports 0,6.
// RULE10 - Lane order fixed after reset completes.
// RULE11 - Reversed port works only as four-lane.
// RULE12 - Reversed port split cannot link single-lane.
// RULE13 - Rate pins drive only in test mode.
// RULE14 - Register bus runs on 100 MHz clock.
// RULE15 - Hard reset asynchronous, active low, keys sampling.
// RULE16 - Capture straps at tenth cycle after release.
`default_nettype none
package spss_pkg;
    // ************************************************************
    // Constants
    // ************************************************************
    localparam int          CLK_MHZ        = 100;
    localparam int          STRAP_HOLD_CYC = 10;
    localparam logic [3:0]  CAP_CNT_LAST   = 4'(STRAP_HOLD_CYC - 1);
    localparam int          NUM_PORTS      = 8;
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STAT       = 4'h1;
    localparam logic [3:0]  REG_RATE_BASE  = 4'h8;
    localparam int          RATE_LSB       = 0;
    localparam int          STAT_DONE_BIT  = 0;
    localparam int          STAT_RXR_BIT   = 1;
    localparam int          STAT_TXR_BIT   = 2;
    localparam int          STAT_SRAW_LSB  = 4;
    localparam int          CTRL_SELF_BIT  = 0;
    localparam int          CTRL_TEST_BIT  = 1;
    localparam int          CTRL_TOUT_LSB  = 4;
    localparam logic [1:0]  RATE_RESET     = 2'h2;
    localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;

    typedef enum logic [1:0] {
        SPSS_RATE_1G25 = 2'h0,
        SPSS_RATE_2G5  = 2'h1,
        SPSS_RATE_3G125 = 2'h2,
        SPSS_RATE_ILL  = 2'h3
    } spss_rate_t;

    typedef struct packed {
        logic [1:0] rate;
        logic       rx_rev;
        logic       tx_rev;
    } spss_strap_t;
endpackage : spss_pkg
`default_nettype wire

/* File: spss_top.sv */
// Added by the designer: the register addresses and the strobed register port.
`default_nettype none
module spss_top
    import spss_pkg::*;
#(
    parameter int NPORT = NUM_PORTS
) (
    // Clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RST_N_I,
    // Straps
    input  wire logic [1:0]  PORT_RATE_STRAP_I,
    output logic      [1:0]  PORT_RATE_STRAP_O,
    output logic      [1:0]  PORT_RATE_STRAP_OE_O,
    input  wire logic        RX_LANE_REVERSE_STRAP_I,
    input  wire logic        TX_LANE_REVERSE_STRAP_I,
    // Self-reset completion pulse
    input  wire logic        SELF_RST_DONE_I,
    // Register port
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // Configuration outputs
    output logic [2*NPORT-1:0] PORT_RATE_O,
    output logic             RATE_ILLEGAL_O,
    output logic             RX_LANE_REVERSE_O,
    output logic             TX_LANE_REVERSE_O,
    output logic             PORT0_X4_ONLY_O,
    output logic             PORT6_X4_ONLY_O,
    output logic             CFG_VALID_O
);
    // ************************************************************
    // Reset release and strap synchronisers
    // ************************************************************
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    spss_strap_t s1_q, s2_q;
    logic        self1_q, self2_q, self3_q;

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin // RULE15
        if (!RST_N_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Straps are pins, so two flops before any logic sees them.
    always_ff @(posedge MCLK_I or negedge rst_n) begin // RULE14
        if (!rst_n) begin
            s1_q    <= '0;
            s2_q    <= '0;
            self1_q <= 1'b0;
            self2_q <= 1'b0;
            self3_q <= 1'b0;
        end else begin
            s1_q    <= '{rate: PORT_RATE_STRAP_I,
                         rx_rev: RX_LANE_REVERSE_STRAP_I,
                         tx_rev: TX_LANE_REVERSE_STRAP_I};
            s2_q    <= s1_q;
            self1_q <= SELF_RST_DONE_I;
            self2_q <= self1_q;
            self3_q <= self2_q;
        end
    end

    // ************************************************************
    // Capture sequencer
    // ************************************************************
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_LOAD = 3'b010,
        ST_RUN  = 3'b100
    } spss_state_t;

    spss_state_t     st_q, st_d;
    logic [3:0]      cnt_q, cnt_d;
    spss_strap_t     cap_q, cap_d;
    logic [1:0]      rate_q [NPORT];
    logic [1:0]      rate_d [NPORT];
    logic            self_en_q, self_en_d;
    logic            test_q, test_d;
    logic [1:0]      tout_q, tout_d;
    logic [31:0]     rdata_q, rdata_d;
    logic            self_done;

    assign self_done = self2_q & ~self3_q;

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        cap_d     = cap_q;
        rate_d    = rate_q;
        self_en_d = self_en_q;
        test_d    = test_q;
        tout_d    = tout_q;
        unique case (st_q)
            ST_WAIT: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == CAP_CNT_LAST) begin // RULE16 RULE5
                    cap_d = s2_q; // RULE10
                    st_d  = ST_LOAD;
                end
            end
            ST_LOAD: begin
                for (int i = 0; i < NPORT; i++) begin
                    rate_d[i] = cap_q.rate; // RULE7 RULE1 RULE3
                end
                st_d = ST_RUN;
            end
            ST_RUN: begin
                // Strap pins are no longer looked at here.
                if (self_done && self_en_q) begin // RULE4
                    st_d = ST_LOAD;
                end
            end
        endcase
        if (WR_I) begin
            if (ADDR_I == REG_CTRL) begin
                self_en_d = WDATA_I[CTRL_SELF_BIT];
                test_d    = WDATA_I[CTRL_TEST_BIT];
                tout_d    = WDATA_I[CTRL_TOUT_LSB +: 2];
            end else if (ADDR_I >= REG_RATE_BASE && st_q == ST_RUN) begin
                rate_d[3'(ADDR_I - REG_RATE_BASE)] =
                    WDATA_I[RATE_LSB +: 2]; // RULE6
            end
        end
    end

    // Reads are answered one cycle later; unmapped addresses read zero.
    always_comb begin
        rdata_d = DATA_ZERO;
        if (RD_I) begin
            if (ADDR_I == REG_CTRL) begin
                rdata_d[CTRL_SELF_BIT]     = self_en_q;
                rdata_d[CTRL_TEST_BIT]     = test_q;
                rdata_d[CTRL_TOUT_LSB +: 2] = tout_q;
            end else if (ADDR_I == REG_STAT) begin
                rdata_d[STAT_DONE_BIT]     = (st_q == ST_RUN);
                rdata_d[STAT_RXR_BIT]      = cap_q.rx_rev;
                rdata_d[STAT_TXR_BIT]      = cap_q.tx_rev;
                rdata_d[STAT_SRAW_LSB +: 2] = cap_q.rate;
            end else if (ADDR_I >= REG_RATE_BASE) begin
                rdata_d[RATE_LSB +: 2] = rate_q[3'(ADDR_I - REG_RATE_BASE)];
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= ST_WAIT;
            cnt_q     <= 4'h0;
            cap_q     <= '0;
            rate_q    <= '{default: RATE_RESET};
            self_en_q <= 1'b0;
            test_q    <= 1'b0;
            tout_q    <= 2'h0;
            rdata_q   <= DATA_ZERO;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            cap_q     <= cap_d;
            rate_q    <= rate_d;
            self_en_q <= self_en_d;
            test_q    <= test_d;
            tout_q    <= tout_d;
            rdata_q   <= rdata_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            PORT_RATE_O[2*i +: 2] = rate_q[i]; // RULE2
        end
    end
    assign RDATA_O              = rdata_q;
    assign RATE_ILLEGAL_O       = (cap_q.rate == SPSS_RATE_ILL); // RULE2
    assign RX_LANE_REVERSE_O    = cap_q.rx_rev; // RULE8
    assign TX_LANE_REVERSE_O    = cap_q.tx_rev; // RULE9
    // A reversed port cannot be split into single-lane ports.
    assign PORT0_X4_ONLY_O      = cap_q.rx_rev | cap_q.tx_rev; // RULE11 RULE12
    assign PORT6_X4_ONLY_O      = cap_q.rx_rev | cap_q.tx_rev; // RULE11
    assign CFG_VALID_O          = (st_q == ST_RUN);
    assign PORT_RATE_STRAP_O    = tout_q;
    assign PORT_RATE_STRAP_OE_O = {2{test_q}}; // RULE13

    // ************************************************************
    // Checks
    // ************************************************************
    capture_time_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        $rose(rst_n) |-> st_q == ST_WAIT [*8]) // RULE16
        else $error("Capture happened too early.");
    load_rate_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_LOAD |=> rate_q[0] == cap_q.rate) // RULE7
        else $error("Rate field not loaded from strap.");
    strap_ignored_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_RUN && $past(st_q) == ST_RUN |-> $stable(cap_q)) // RULE10
        else $error("Strap value changed after reset.");
    self_reload_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_RUN && self_done && self_en_q |=> st_q == ST_LOAD) // RULE4
        else $error("Self-reset did not reload rate.");
    test_drive_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        !test_q |-> PORT_RATE_STRAP_OE_O == 2'h0) // RULE13
        else $error("Rate pins driven outside test mode.");
    rate_write_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        WR_I && ADDR_I == REG_RATE_BASE && st_q == ST_RUN |=>
        rate_q[0] == $past(WDATA_I[1:0])) // RULE6
        else $error("Rate override lost.");
    x4_only_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        RX_LANE_REVERSE_O |-> PORT0_X4_ONLY_O && PORT6_X4_ONLY_O) // RULE11
        else $error("Reversed port not four-lane only.");
    all_ports_a: assert property (@(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_LOAD |=> rate_q[NPORT-1] == rate_q[0]) // RULE1
        else $error("Ports got different default rates.");

    // ************************************************************
    // Output and internal state checks
    // ************************************************************
    // Before count_range_a these watch the ports, so a wrong wire-up shows up here too.
    rate_illegal_a: assert property ( // RULE2
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_LOAD |=> RATE_ILLEGAL_O == (rate_q[0] == SPSS_RATE_ILL))
        else $error("Illegal rate flag wrong.");

    rx_capture_a: assert property ( // RULE8
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_LOAD && $past(st_q) == ST_WAIT |->
        RX_LANE_REVERSE_O == $past(s2_q.rx_rev))
        else $error("Receive lane order not captured.");

    tx_capture_a: assert property ( // RULE9
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_LOAD && $past(st_q) == ST_WAIT |->
        TX_LANE_REVERSE_O == $past(s2_q.tx_rev))
        else $error("Transmit lane order not captured.");

    lane_fixed_a: assert property ( // RULE10
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_RUN |=>
        $stable({RX_LANE_REVERSE_O, TX_LANE_REVERSE_O}))
        else $error("Lane order moved after reset.");

    tx_x4_only_a: assert property ( // RULE12
        @(posedge MCLK_I) disable iff (!rst_n)
        TX_LANE_REVERSE_O |-> PORT0_X4_ONLY_O && PORT6_X4_ONLY_O)
        else $error("Transmit reversed port not four-lane only.");

    test_enable_a: assert property ( // RULE13
        @(posedge MCLK_I) disable iff (!rst_n)
        test_q |-> PORT_RATE_STRAP_OE_O == 2'h3)
        else $error("Rate pins not driven in test mode.");

    early_write_a: assert property ( // RULE6
        @(posedge MCLK_I) disable iff (!rst_n)
        WR_I && ADDR_I >= REG_RATE_BASE && st_q == ST_WAIT |=>
        $stable(PORT_RATE_O))
        else $error("Rate write taken before capture.");

    read_stands_a: assert property ( // RULE14
        @(posedge MCLK_I) disable iff (!rst_n)
        !RD_I |=> RDATA_O == DATA_ZERO)
        else $error("Read data stood too long.");

    status_done_a: assert property ( // RULE3
        @(posedge MCLK_I) disable iff (!rst_n)
        RD_I && ADDR_I == REG_STAT |=>
        RDATA_O[STAT_DONE_BIT] == $past(CFG_VALID_O))
        else $error("Status done bit wrong.");

    valid_rise_a: assert property ( // RULE3
        @(posedge MCLK_I) disable iff (!rst_n)
        $rose(CFG_VALID_O) |-> $past(st_q) == ST_LOAD)
        else $error("Configuration valid without load.");

    count_range_a: assert property ( // RULE16
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_WAIT |-> cnt_q <= CAP_CNT_LAST)
        else $error("Capture counter ran past its end.");

    capture_once_a: assert property ( // RULE10
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q != ST_WAIT |=> st_q != ST_WAIT)
        else $error("Straps sampled a second time.");

    reload_rate_a: assert property ( // RULE4
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_LOAD |=> PORT_RATE_O == {NPORT{cap_q.rate}})
        else $error("Ports not loaded with strapped rate.");

    run_hold_a: assert property ( // RULE6
        @(posedge MCLK_I) disable iff (!rst_n)
        st_q == ST_RUN && !(self_done && self_en_q) |=> st_q == ST_RUN)
        else $error("Left run without a self-reset.");

    state_code_a: assert property (
        @(posedge MCLK_I) disable iff (!rst_n)
        $onehot(st_q))
        else $error("Sequencer state not one-hot.");

    strap_sync_a: assert property ( // RULE15
        @(posedge MCLK_I) disable iff (!rst_n)
        s2_q == $past(s1_q))
        else $error("Strap synchroniser skipped a stage.");

    ctrl_read_a: assert property ( // RULE13
        @(posedge MCLK_I) disable iff (!rst_n)
        RD_I && ADDR_I == REG_CTRL |=>
        RDATA_O[CTRL_TEST_BIT] == $past(test_q))
        else $error("Control read back wrong.");
endmodule : spss_top
`default_nettype wire

/* File: spss_strap_model.sv */
`default_nettype none
// ****************************************************
// Board straps and the two-way rate pins.
// ****************************************************
module spss_strap_model (
    // Board resistor levels
    input  wire logic [1:0] rate_sel_i,
    input  wire logic       rx_sel_i,
    input  wire logic       tx_sel_i,
    // Device side of the rate pins
    input  wire logic [1:0] drv_i,
    input  wire logic [1:0] oe_i,
    // Pin levels seen by the device
    output logic      [1:0] rate_pin_o,
    output logic            rx_pin_o,
    output logic            tx_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin overrides its resistor, so test drive shows on the pin.
    assign rate_pin_o = (oe_i & drv_i) | (~oe_i & rate_sel_i);
    // Levels only change when the bench says so, during hard reset or after capture.
    assign rx_pin_o   = rx_sel_i;
    assign tx_pin_o   = tx_sel_i;
endmodule // spss_strap_model
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb;
    import spss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, self_done = 0, wr = 0, rd = 0, rx = 0, tx = 0;
    logic [1:0] sel = 2'h2, pin, sdo, soe;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic [15:0] prate;
    logic ill, rxr, txr, x40, x46, valid, rxp, txp;
    int miscompares = 0, n_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    spss_strap_model model (.rate_sel_i(sel), .rx_sel_i(rx), .tx_sel_i(tx),
        .drv_i(sdo), .oe_i(soe), .rate_pin_o(pin), .rx_pin_o(rxp),
        .tx_pin_o(txp));
    spss_top uut (.MCLK_I(clk), .RST_N_I(rst_n), .PORT_RATE_STRAP_I(pin),
        .PORT_RATE_STRAP_O(sdo), .PORT_RATE_STRAP_OE_O(soe),
        .RX_LANE_REVERSE_STRAP_I(rxp), .TX_LANE_REVERSE_STRAP_I(txp),
        .SELF_RST_DONE_I(self_done), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PORT_RATE_O(prate),
        .RATE_ILLEGAL_O(ill), .RX_LANE_REVERSE_O(rxr),
        .TX_LANE_REVERSE_O(txr), .PORT0_X4_ONLY_O(x40),
        .PORT6_X4_ONLY_O(x46), .CFG_VALID_O(valid));
    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic hard_reset(logic [1:0] r, logic x, logic t);
        @(posedge clk);
        rst_n <= 1'b0; sel <= r; rx <= x; tx <= t;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 40 && valid !== 1'b1; i++) @(posedge clk);
        chk("cfg_valid", 32'(valid), 32'h0000_0001);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    // ****************************************************
    // Test sequence
    // ****************************************************
    initial begin
        for (int c = 0; c < 4; c++) begin
            hard_reset(2'(c), c[0], c[1]);
            chk("illegal", 32'(ill), 32'(c == 3));
            if (c != 3) chk("rate", 32'(prate), {16'h0, {8{2'(c)}}});
            chk("rx_rev", 32'(rxr), 32'(c[0]));
            chk("tx_rev", 32'(txr), 32'(c[1]));
            chk("x4_0", 32'(x40), 32'(c != 0));
            chk("x4_6", 32'(x46), 32'(c != 0));
            rd_reg(4'h1, d);
            chk("status", d, 32'(c << 4 | c[1] << 2 | c[0] << 1 | 1));
        end
        hard_reset(2'h1, 1'b1, 1'b0);
        sel <= 2'h0; rx <= 1'b0; tx <= 1'b1;
        repeat (6) @(posedge clk);
        chk("rate_hold", 32'(prate), 32'h0000_5555);
        chk("lane_hold", {rxr, txr}, 32'h0000_0002);
        wr_reg(4'hB, 32'h0000_0000);
        rd_reg(4'hB, d);
        chk("rate_rd", d, 32'h0000_0000);
        chk("rate_sw", 32'(prate), 32'h0000_5515);
        rd_reg(4'h3, d);
        chk("unmapped", d, 32'h0000_0000);
        wr_reg(4'h0, 32'h0000_0032);
        repeat (2) @(posedge clk);
        chk("test_oe", 32'(soe), 32'h0000_0003);
        chk("test_pin", 32'(pin), 32'h0000_0003);
        wr_reg(4'h0, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("norm_oe", 32'(soe), 32'h0000_0000);
        self_done <= 1'b1;
        repeat (3) @(posedge clk);
        self_done <= 1'b0;
        for (int i = 0; i < 30 && prate !== 16'h5555; i++) @(posedge clk);
        chk("self_rate", 32'(prate), 32'h0000_5555);
        chk("self_lane", {rxr, txr}, 32'h0000_0002);
        rd_reg(4'hB, d);
        chk("self_rd", d, 32'h0000_0001);
        complete_run();
    end
endmodule // tb
`default_nettype wire
